// [lpws_pkg.sv]
package lpws_pkg;
	localparam logic [1:0] LPWS_MODE_IDLE = 2'h0;
	localparam logic [1:0] LPWS_MODE_STANDBY = 2'h1;
	localparam logic [1:0] LPWS_MODE_HALT = 2'h2;
	localparam int LPWS_FLUSH_CYC = 32;
	localparam int LPWS_IDLE_FAST_CYC = 8;
	localparam int LPWS_IDLE_SLEEP_CYC = 1050;
	localparam int LPWS_STBY_FAST_OSC = 12;
	localparam int LPWS_STBY_SLEEP_CYC = 1125;
	localparam int LPWS_HALT_SLEEP_CYC = 1125;
	localparam int LPWS_HALT_RAM_CYC = 35;
	localparam int LPWS_PLL_LOCK_OSC = 131072;
	localparam int LPWS_UNQ_IDLE_MIN = 2;
	localparam int LPWS_UNQ_STBY_MIN = 12;
	localparam int LPWS_STBY_QUAL_BASE = 2;
	localparam int LPWS_NMI_MIN_OSC = 2;
	localparam int LPWS_RST_MIN_OSC = 8;
	localparam int LPWS_QUAL_WINDOWS = 5;
	localparam logic [1:0] LPWS_OSC_DIV = 2'h1;
	localparam logic [20:0] LPWS_CNT_ZERO = 21'h0;
	typedef struct packed {
		logic [1:0] mode;
		logic [5:0] stby_qual;
		logic [7:0] qual_prd;
		logic code_in_flash;
		logic flash_asleep;
	} lpws_cfg_t;
	typedef struct packed {
		logic any_int;
		logic int_enabled;
		logic watchdog_interrupt;
		logic nmi_wake_pin;
		logic reset_pin;
	} lpws_wake_t;
	typedef enum logic [3:0] {
		LPWS_RUN, LPWS_FLUSH, LPWS_IDLE_WAIT, LPWS_STBY_WAIT, LPWS_HALT_OFF,
		LPWS_HALT_OSC, LPWS_PLL_LOCK, LPWS_RESUME
	} lpws_state_t;
endpackage

// [lpws_sequencer.sv]
`timescale 1ns/1ps
`default_nettype none
module lpws_sequencer #(
	parameter int PLL_LOCK_OSC = lpws_pkg::LPWS_PLL_LOCK_OSC,
	parameter int IDLE_SLEEP_CYC = lpws_pkg::LPWS_IDLE_SLEEP_CYC,
	parameter int STBY_SLEEP_CYC = lpws_pkg::LPWS_STBY_SLEEP_CYC,
	parameter int HALT_SLEEP_CYC = lpws_pkg::LPWS_HALT_SLEEP_CYC
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic osc_tick,
	input wire logic idle_exec,
	input wire lpws_pkg::lpws_cfg_t cfg,
	input wire lpws_pkg::lpws_wake_t wake,
	output logic system_clock_en,
	output logic core_input_clock_en,
	output logic external_clock_out,
	output logic osc_enable,
	output logic pll_enable,
	output logic resume,
	output logic take_interrupt,
	output logic low_power
);
	lpws_pkg::lpws_state_t st_q, st_d;
	logic [20:0] cnt_q, cnt_d;
	logic [1:0] mode_q, mode_d;
	logic [8:0] qdiv_q, qdiv_d;
	logic [5:0] hist_q, hist_d;
	logic [20:0] pw_q, pw_d;
	logic nmi_q, nmi_d;
	logic ten_q, ten_d;

	localparam logic [20:0] LPWS_CNT0 = lpws_pkg::LPWS_CNT_ZERO;

	function automatic logic [20:0] c21(input int v);
		c21 = v[20:0];
	endfunction

	logic sample;
	logic idle_src;
	logic qual_ok;
	logic wake_src;
	assign idle_src = wake.any_int | wake.watchdog_interrupt |
		wake.nmi_wake_pin | wake.reset_pin;
	assign sample = (qdiv_q == 9'h000);
	assign qual_ok = (cfg.qual_prd == 8'h00) ? idle_src : (&hist_q);
	assign wake_src = wake.nmi_wake_pin | wake.reset_pin | wake.any_int;

	always_comb
	begin
		st_d = st_q;
		cnt_d = cnt_q;
		mode_d = mode_q;
		qdiv_d = qdiv_q;
		hist_d = hist_q;
		pw_d = pw_q;
		nmi_d = wake.nmi_wake_pin;
		ten_d = 1'b0;
		if (cfg.qual_prd != 8'h00)
		begin
			if (sample)
			begin
				qdiv_d = {cfg.qual_prd, 1'b0} - 9'h001;
				hist_d = {hist_q[4:0], idle_src};
			end
			else
			begin
				qdiv_d = qdiv_q - 9'h001;
			end
		end
		else
		begin
			qdiv_d = 9'h000;
			hist_d = 6'h00;
		end
		case (st_q)
			lpws_pkg::LPWS_RUN:
			begin
				cnt_d = LPWS_CNT0;
				if (idle_exec)
				begin
					mode_d = cfg.mode;
					if (cfg.mode == lpws_pkg::LPWS_MODE_IDLE)
					begin
						st_d = lpws_pkg::LPWS_IDLE_WAIT;
					end
					else
					begin
						st_d = lpws_pkg::LPWS_FLUSH;
					end
				end
			end
			lpws_pkg::LPWS_FLUSH:
			begin
				cnt_d = cnt_q + 21'h1;
				if (cnt_q == c21(lpws_pkg::LPWS_FLUSH_CYC - 1))
				begin
					cnt_d = LPWS_CNT0;
					pw_d = LPWS_CNT0;
					if (mode_q == lpws_pkg::LPWS_MODE_HALT)
					begin
						st_d = lpws_pkg::LPWS_HALT_OFF;
					end
					else
					begin
						st_d = lpws_pkg::LPWS_STBY_WAIT;
					end
				end
			end
			lpws_pkg::LPWS_IDLE_WAIT:
			begin
				if (qual_ok)
				begin
					st_d = lpws_pkg::LPWS_RESUME;
					cnt_d = (cfg.code_in_flash && cfg.flash_asleep) ?
						c21(IDLE_SLEEP_CYC) :
						c21(lpws_pkg::LPWS_IDLE_FAST_CYC);
				end
			end
			lpws_pkg::LPWS_STBY_WAIT:
			begin
				if (osc_tick)
				begin
					if (wake_src)
					begin
						pw_d = pw_q + 21'h1;
					end
					else
					begin
						pw_d = LPWS_CNT0;
					end
					if (wake_src && (pw_q + 21'h1 >= ((cfg.qual_prd == 8'h00) ?
						c21(lpws_pkg::LPWS_UNQ_STBY_MIN) :
						c21(lpws_pkg::LPWS_STBY_QUAL_BASE) +
						{15'h0, cfg.stby_qual})))
					begin
						st_d = lpws_pkg::LPWS_RESUME;
						cnt_d = (cfg.code_in_flash && cfg.flash_asleep) ?
							c21(STBY_SLEEP_CYC) :
							c21(2 * lpws_pkg::LPWS_STBY_FAST_OSC);
					end
				end
			end
			lpws_pkg::LPWS_HALT_OFF:
			begin
				if (osc_tick && wake.reset_pin)
				begin
					pw_d = pw_q + 21'h1;
				end
				else if (osc_tick)
				begin
					pw_d = LPWS_CNT0;
				end
				if (wake.nmi_wake_pin && !nmi_q)
				begin
					st_d = lpws_pkg::LPWS_HALT_OSC;
					pw_d = {20'h0, osc_tick};
				end
				else if (pw_q >= c21(lpws_pkg::LPWS_RST_MIN_OSC))
				begin
					st_d = lpws_pkg::LPWS_PLL_LOCK;
					cnt_d = LPWS_CNT0;
				end
			end
			lpws_pkg::LPWS_HALT_OSC:
			begin
				if (osc_tick && wake.nmi_wake_pin)
				begin
					pw_d = pw_q + 21'h1;
				end
				if (!wake.nmi_wake_pin)
				begin
					if (pw_q >= c21(lpws_pkg::LPWS_NMI_MIN_OSC))
					begin
						st_d = lpws_pkg::LPWS_PLL_LOCK;
						cnt_d = LPWS_CNT0;
					end
					else
					begin
						st_d = lpws_pkg::LPWS_HALT_OFF;
						pw_d = LPWS_CNT0;
					end
				end
			end
			lpws_pkg::LPWS_PLL_LOCK:
			begin
				if (osc_tick)
				begin
					cnt_d = cnt_q + 21'h1;
				end
				if (cnt_q == c21(PLL_LOCK_OSC))
				begin
					st_d = lpws_pkg::LPWS_RESUME;
					cnt_d = (cfg.code_in_flash && cfg.flash_asleep) ?
						c21(HALT_SLEEP_CYC) :
						c21(lpws_pkg::LPWS_HALT_RAM_CYC);
				end
			end
			lpws_pkg::LPWS_RESUME:
			begin
				cnt_d = cnt_q - 21'h1;
				if (cnt_q == 21'h1)
				begin
					st_d = lpws_pkg::LPWS_RUN;
					ten_d = wake.int_enabled;
				end
			end
			default:
			begin
				st_d = lpws_pkg::LPWS_RUN;
			end
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			st_q <= lpws_pkg::LPWS_RUN;
			cnt_q <= LPWS_CNT0;
			mode_q <= lpws_pkg::LPWS_MODE_IDLE;
			qdiv_q <= 9'h000;
			hist_q <= 6'h00;
			pw_q <= LPWS_CNT0;
			nmi_q <= 1'b0;
			ten_q <= 1'b0;
		end
		else
		begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			mode_q <= mode_d;
			qdiv_q <= qdiv_d;
			hist_q <= hist_d;
			pw_q <= pw_d;
			nmi_q <= nmi_d;
			ten_q <= ten_d;
		end
	end

	logic stopped;
	assign stopped = (st_q == lpws_pkg::LPWS_STBY_WAIT) ||
		(st_q == lpws_pkg::LPWS_HALT_OFF) ||
		(st_q == lpws_pkg::LPWS_HALT_OSC) ||
		(st_q == lpws_pkg::LPWS_PLL_LOCK);
	assign system_clock_en = !stopped;
	assign core_input_clock_en = !stopped;
	assign external_clock_out = stopped;
	assign osc_enable = (st_q != lpws_pkg::LPWS_HALT_OFF);
	assign pll_enable = (st_q != lpws_pkg::LPWS_HALT_OFF) &&
		(st_q != lpws_pkg::LPWS_HALT_OSC);
	assign resume = (st_q == lpws_pkg::LPWS_RESUME) && (cnt_q == 21'h1);
	assign take_interrupt = ten_q;
	assign low_power = (st_q != lpws_pkg::LPWS_RUN);
endmodule // lpws_sequencer
`default_nettype wire

// [lpws_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module lpws_sva (
	input wire logic clk,
	input wire logic rstn,
	input wire logic idle_exec,
	input wire lpws_pkg::lpws_cfg_t cfg,
	input wire lpws_pkg::lpws_wake_t wake,
	input wire logic system_clock_en,
	input wire logic core_input_clock_en,
	input wire logic external_clock_out,
	input wire logic osc_enable,
	input wire logic pll_enable,
	input wire logic resume,
	input wire logic take_interrupt,
	input wire logic low_power
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	a_flush_then_stop: assert property (
		idle_exec && !low_power &&
		cfg.mode != lpws_pkg::LPWS_MODE_IDLE |->
		system_clock_en [*8] ##[25:27] !system_clock_en) else $error("stop");
	a_ext_clk_late: assert property (
		$rose(external_clock_out) |-> $past(low_power, 31)) else $error("ext");
	a_ext_when_off: assert property (
		external_clock_out |-> !system_clock_en && $past(low_power, 32))
		else $error("off");
	a_flush_exact: assert property (
		$rose(external_clock_out) |-> $past(idle_exec, 33))
		else $error("flush");
	a_core_clk_stop: assert property (
		$fell(core_input_clock_en) |-> $past(idle_exec, 33))
		else $error("core");
	a_pll_with_osc: assert property (
		!osc_enable |-> !pll_enable) else $error("pll");
	a_osc_alone: assert property (
		$rose(osc_enable) && $past(wake.nmi_wake_pin) |-> !pll_enable)
		else $error("osc");
	a_resume_pulse: assert property (
		resume |=> !resume) else $error("resume");
	a_take_enabled: assert property (
		resume && wake.int_enabled |=> take_interrupt) else $error("take");
	a_take_cause: assert property (
		take_interrupt |-> $past(resume) && $past(wake.int_enabled))
		else $error("cause");
endmodule // lpws_sva
bind lpws_sequencer lpws_sva i_lpws_sva (.*);
`default_nettype wire

// [lpws_wake_src.sv]
`timescale 1ns/1ps
`default_nettype none
module lpws_wake_src (
	input wire logic clk,
	input wire logic fire,
	input wire logic [2:0] sel,
	input wire logic [7:0] len,
	input wire logic int_en,
	output var lpws_pkg::lpws_wake_t wake
);
	logic [7:0] cnt_q = 8'h0;
	logic [2:0] sel_q = 3'h0;
	always_ff @(posedge clk)
	begin
		if (fire)
		begin
			cnt_q <= len;
			sel_q <= sel;
		end
		else if (cnt_q != 8'h0)
			cnt_q <= cnt_q - 8'h1;
	end
	// Holds one source for the given width.
	always_comb
	begin
		wake = '0;
		wake.int_enabled = int_en;
		if (cnt_q != 8'h0)
			wake[3'h4 - sel_q] = 1'b1;
	end
endmodule // lpws_wake_src
`default_nettype wire

// [lpws_sequencer_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fails++; \
	$display("unexpected %0t: %0d vs %0d", $time, a, b); end end
module lpws_sequencer_tb;
	typedef struct {int lo; int hi; logic en;} lpws_exp_t;
	logic clk = 1'b0, rstn = 1'b0, osc_tick = 1'b0, idle_exec = 1'b0;
	logic fire = 1'b0, int_en = 1'b0, take_interrupt, resume;
	logic [2:0] sel = 3'h0;
	logic [7:0] len = 8'h0;
	logic [31:0] seed = 32'h3aabc3bb;
	lpws_pkg::lpws_cfg_t cfg = '0;
	lpws_pkg::lpws_wake_t wake;
	lpws_exp_t exp_q[$];
	int fails = 0, cmp_count = 0, done = 0;
	time t0;
	// Mode, flash, qual period, source, width, latency window.
	int tv[8][7] = '{'{0, 0, 0, 0, 2, 8, 16}, '{0, 2, 0, 2, 2, 60, 70},
		'{0, 0, 1, 0, 12, 18, 28}, '{1, 1, 0, 3, 24, 24, 58},
		'{1, 2, 0, 4, 24, 70, 104}, '{2, 0, 0, 3, 4, 67, 86},
		'{2, 2, 0, 4, 16, 120, 142}, '{1, 0, 1, 0, 140, 26, 34}};
	always #5 clk = ~clk;
	always @(posedge clk) osc_tick <= ~osc_tick;
	lpws_wake_src i_lpws_wake_src (.clk(clk), .fire(fire), .sel(sel),
		.len(len), .int_en(int_en), .wake(wake));
	lpws_sequencer #(.PLL_LOCK_OSC(16), .IDLE_SLEEP_CYC(60),
		.STBY_SLEEP_CYC(70), .HALT_SLEEP_CYC(80)) i_lpws_sequencer (
		.clk(clk), .rstn(rstn), .osc_tick(osc_tick), .idle_exec(idle_exec),
		.cfg(cfg), .wake(wake), .system_clock_en(), .core_input_clock_en(),
		.external_clock_out(), .osc_enable(), .pll_enable(),
		.resume(resume), .take_interrupt(take_interrupt), .low_power());
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic pulse_idle();
		@(posedge clk);
		#1;
		idle_exec = 1'b1;
		@(posedge clk);
		#1;
		idle_exec = 1'b0;
		repeat (20) @(posedge clk);
	endtask
	task automatic run_case(input int i);
		logic [31:0] r;
		int q2;
		@(posedge clk);
		#1;
		r = xs();
		q2 = (tv[i][0] == 1 && tv[i][2] != 0) ? 2 * int'(r[7:2]) : 0;
		cfg.mode = 2'(tv[i][0]);
		cfg.code_in_flash = tv[i][1] != 0;
		cfg.flash_asleep = tv[i][1] == 2;
		cfg.qual_prd = 8'(tv[i][2]);
		cfg.stby_qual = 6'(r[7:2]);
		int_en = r[0] | (tv[i][3] == 0);
		exp_q.push_back('{tv[i][5] + q2, tv[i][6] + q2, int_en});
		pulse_idle();
		pulse_idle();
		t0 = $time;
		#1;
		sel = 3'(tv[i][3]);
		len = 8'(tv[i][4]);
		fire = 1'b1;
		@(posedge clk);
		#1;
		fire = 1'b0;
		for (int k = 0; k < 400 && done <= i; k++) @(posedge clk);
		`CHK(done, i + 1)
		$display("case %0d finished", i);
	endtask
	always @(posedge clk)
		if (resume === 1'b1)
		begin
			lpws_exp_t e;
			int lat;
			e = exp_q.pop_front();
			lat = int'(($time - t0) / 10);
			`CHK(lat >= e.lo && lat <= e.hi, 1'b1)
			@(posedge clk);
			`CHK(take_interrupt, e.en)
			done++;
		end
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial
	begin
		#50000;
		fails++;
		end_of_test();
	end
	initial
	begin
		repeat (20) @(posedge clk);
		#1;
		rstn = 1'b1;
		for (int i = 0; i < 8; i++)
			run_case(i);
		end_of_test();
	end
endmodule // lpws_sequencer_tb
`undef CHK
`default_nettype wire
